//--- logic/irq_sc_pkg.sv
// Shared constants, register selectors and request carrier for the interrupt
// enable and status-change masking block.
// Assumes one register access per cycle from the I/O space decoder.
package irq_sc_pkg;

  // Register selector driven by the I/O space decoder
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FORCE,
    SEL_LATCH,
    SEL_MASK,
    SEL_PRESENT,
    SEL_ENABLE,
    SEL_CAUSE,
    SEL_CAUSE_ACK
  } reg_sel_t;

  // One register access
  typedef struct packed {
    logic wr;
    logic rd;
    reg_sel_t sel;
    logic [31:0] wdata;
  } reg_req_t;

  localparam int REG_W = 32;
  localparam int CAUSE_W = 16;

  // Status-change field positions
  localparam int SC_GENERAL_WAKE = 4;
  localparam int SC_WAKE_MASTER_ENABLE = 14;
  localparam int SC_FUNCTION_INTERRUPT = 15;

  // Interrupt cause positions
  localparam int CAUSE_LINE_ACTIVE = 0;
  localparam int CAUSE_BUS_FAULT = 1;
  localparam int CAUSE_MODEM_REQUEST = 11;

  // Enable bits software may write; bit 11 only with the modem option
  localparam logic [15:0] ENABLE_WRITABLE_BASE = 16'h07fe;
  localparam logic [15:0] ENABLE_WRITABLE_MODEM = 16'h0ffe;

  // Bits that may actually raise an interrupt (bit 5 is storage only)
  localparam logic [15:0] CAUSE_SOURCES_BASE = 16'h07de;
  localparam logic [15:0] CAUSE_SOURCES_MODEM = 16'h0fde;

  // Values after reset
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

//--- logic/sticky_event_bit.sv
// One status-change event flag: set by hardware, cleared by a write of one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sticky_event_bit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_enable,
  input wire logic i_set,
  input wire logic i_clear,
  // State
  output logic o_flag
);

  logic flag;
  wire logic next_flag;

  // A set in the clearing cycle is kept, so no event is lost
  assign next_flag = !i_enable ? 1'b0 : (i_set ? 1'b1 : (i_clear ? 1'b0 : flag));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign o_flag = flag;

endmodule
`default_nettype wire

//--- logic/irq_source_gate.sv
// Per-source interrupt gating: each cause bit passes only with its enable.
// Assumes cause bits are already latched by the interrupt status logic.
`timescale 1ns/10ps
`default_nettype none
module irq_source_gate (
  // Sources
  input wire logic [15:0] i_cause,
  input wire logic [15:0] i_enable,
  input wire logic [15:0] i_sources,
  // Result
  output logic [15:0] o_gated,
  output logic o_any
);

  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_bit
      assign o_gated[b] = i_cause[b] & i_enable[b] & i_sources[b];
    end
  endgenerate

  assign o_any = |o_gated;

endmodule
`default_nettype wire

//--- logic/irq_status_change.sv
// Interrupt enable, status-change mask and present-state logic with the
// bus interrupt and status-change outputs.
// Assumes a decoder on the PCI clock presents one access per cycle and
// that cause, wake and card-mode inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module irq_status_change
  import irq_sc_pkg::*;
#(
  parameter bit MODEM_PRESENT = 1'b0
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Register access
  input wire reg_req_t I_REG_REQ,
  output logic [31:0] O_REG_RDATA,
  // Chip state
  input wire logic I_CARD_MODE,
  input wire logic [15:0] I_CAUSE,
  input wire logic I_WAKE_LIVE,
  // Power management
  output logic O_POWER_EVENT_CLEAR,
  // Interrupt outputs
  output logic O_BUS_INTERRUPT_OUT_N,
  output logic O_STATUS_CHANGE_OUT_N,
  output logic O_INTERRUPT_LINE_ACTIVE
);

  localparam logic [15:0] ENABLE_WRITABLE = MODEM_PRESENT ? ENABLE_WRITABLE_MODEM : ENABLE_WRITABLE_BASE;
  localparam logic [15:0] CAUSE_SOURCES = MODEM_PRESENT ? CAUSE_SOURCES_MODEM : CAUSE_SOURCES_BASE;

  logic [15:0] interrupt_source_enable;
  logic [31:0] status_change_mask;
  logic [31:0] rdata;
  logic bus_irq;
  logic status_change;
  logic power_clear;
  logic general_wake;
  logic function_interrupt;

  wire logic [15:0] gated_cause;
  wire logic any_pending;

  // Access decode
  wire logic wr_force = I_REG_REQ.wr && (I_REG_REQ.sel == SEL_FORCE);
  wire logic wr_latch = I_REG_REQ.wr && (I_REG_REQ.sel == SEL_LATCH);
  wire logic wr_mask = I_REG_REQ.wr && (I_REG_REQ.sel == SEL_MASK);
  wire logic wr_enable = I_REG_REQ.wr && (I_REG_REQ.sel == SEL_ENABLE);
  wire logic rd_ack = I_REG_REQ.rd && (I_REG_REQ.sel == SEL_CAUSE_ACK);

  irq_source_gate u_gate (
    .i_cause(I_CAUSE),
    .i_enable(interrupt_source_enable),
    .i_sources(CAUSE_SOURCES),
    .o_gated(gated_cause),
    .o_any(any_pending)
  );

  // Card mode off disables mask, present view and event latch
  wire logic [31:0] mask_eff = I_CARD_MODE ? status_change_mask : 32'h0000_0000;

  wire logic force_wake = wr_force && I_REG_REQ.wdata[SC_GENERAL_WAKE];
  wire logic force_func = wr_force && I_REG_REQ.wdata[SC_FUNCTION_INTERRUPT];
  wire logic clr_wake = wr_latch && I_REG_REQ.wdata[SC_GENERAL_WAKE];
  wire logic clr_func = wr_latch && I_REG_REQ.wdata[SC_FUNCTION_INTERRUPT];

  sticky_event_bit u_wake (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_enable(I_CARD_MODE),
    .i_set(I_WAKE_LIVE || force_wake),
    .i_clear(clr_wake),
    .o_flag(general_wake)
  );

  sticky_event_bit u_func (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_enable(I_CARD_MODE),
    .i_set(any_pending || force_func),
    .i_clear(clr_func),
    .o_flag(function_interrupt)
  );

  // Present-state view
  wire logic [31:0] present_view = {16'h0000, any_pending, 10'h000, I_WAKE_LIVE, 4'h0};
  wire logic [31:0] present_eff = I_CARD_MODE ? present_view : 32'h0000_0000;
  wire logic [31:0] latch_view = {16'h0000, function_interrupt, 10'h000, general_wake, 4'h0};
  wire logic [31:0] mask_view = {16'h0000, mask_eff[15:14], 9'h000, mask_eff[4], 4'h0};
  wire logic [15:0] cause_view = {I_CAUSE[15:1], bus_irq};

  // Output qualification; the function-interrupt path only exists in card mode
  wire logic func_drive = mask_eff[SC_FUNCTION_INTERRUPT] && function_interrupt;
  wire logic next_bus_irq = any_pending || func_drive;
  wire logic next_status_change = mask_eff[SC_WAKE_MASTER_ENABLE] && mask_eff[SC_GENERAL_WAKE]
                                  && general_wake;

  wire logic [15:0] next_enable = rd_ack ? ENABLE_RESET
                                  : (wr_enable ? (I_REG_REQ.wdata[15:0] & ENABLE_WRITABLE)
                                  : interrupt_source_enable);
  wire logic [31:0] next_mask = (wr_mask && I_CARD_MODE) ? (I_REG_REQ.wdata & 32'h0000_c010)
                                : status_change_mask;

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (I_REG_REQ.rd) begin
      unique case (I_REG_REQ.sel)
        SEL_NONE: next_rdata = 32'h0000_0000;
        SEL_FORCE: next_rdata = 32'h0000_0000;
        SEL_LATCH: next_rdata = latch_view;
        SEL_MASK: next_rdata = mask_view;
        SEL_PRESENT: next_rdata = present_eff;
        SEL_ENABLE: next_rdata = {16'h0000, interrupt_source_enable};
        SEL_CAUSE: next_rdata = {16'h0000, cause_view};
        SEL_CAUSE_ACK: next_rdata = {16'h0000, cause_view};
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      interrupt_source_enable <= ENABLE_RESET;
      status_change_mask <= MASK_RESET;
      rdata <= RDATA_RESET;
      bus_irq <= 1'b0;
      status_change <= 1'b0;
      power_clear <= 1'b0;
    end else begin
      interrupt_source_enable <= next_enable;
      status_change_mask <= next_mask;
      rdata <= next_rdata;
      bus_irq <= next_bus_irq;
      status_change <= next_status_change;
      power_clear <= clr_wake && I_CARD_MODE;
    end
  end

  assign O_REG_RDATA = rdata;
  assign O_POWER_EVENT_CLEAR = power_clear;
  assign O_BUS_INTERRUPT_OUT_N = !bus_irq;
  assign O_STATUS_CHANGE_OUT_N = !status_change;
  assign O_INTERRUPT_LINE_ACTIVE = bus_irq;

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  wire logic rd_present = I_REG_REQ.rd && (I_REG_REQ.sel == SEL_PRESENT);
  wire logic rd_mask = I_REG_REQ.rd && (I_REG_REQ.sel == SEL_MASK);
  wire logic rd_enable = I_REG_REQ.rd && (I_REG_REQ.sel == SEL_ENABLE);
  wire logic rd_cause = I_REG_REQ.rd && (I_REG_REQ.sel == SEL_CAUSE);
  wire logic wr_ro = I_REG_REQ.wr && ((I_REG_REQ.sel == SEL_PRESENT) || (I_REG_REQ.sel == SEL_CAUSE));

  chk_card_present_off: assert property (
    rd_present && !I_CARD_MODE |=> O_REG_RDATA == 32'h0000_0000)
    else $error("present state visible with card mode low");

  chk_card_status_quiet: assert property (
    !I_CARD_MODE |=> O_STATUS_CHANGE_OUT_N)
    else $error("status change driven with card mode low");

  chk_wake_drives_sc: assert property (
    I_CARD_MODE && status_change_mask[14] && status_change_mask[4] && general_wake
    |=> !O_STATUS_CHANGE_OUT_N)
    else $error("general wake did not drive status change");

  chk_master_wake_gate: assert property (
    !status_change_mask[SC_WAKE_MASTER_ENABLE] |=> O_STATUS_CHANGE_OUT_N)
    else $error("status change driven without master wake enable");

  chk_func_drives_irq: assert property (
    I_CARD_MODE && status_change_mask[15] && function_interrupt |=> !O_BUS_INTERRUPT_OUT_N)
    else $error("function interrupt event did not drive bus interrupt");

  chk_present_wake_bit: assert property (
    rd_present && I_CARD_MODE |=> O_REG_RDATA[4] == $past(I_WAKE_LIVE))
    else $error("present wake bit differs from live wake");

  chk_present_or_bit: assert property (
    rd_present && I_CARD_MODE |=> O_REG_RDATA[15] == $past(any_pending))
    else $error("present interrupt bit differs from enabled causes");

  chk_enable_passes: assert property (
    (I_CAUSE & interrupt_source_enable & CAUSE_SOURCES) != 16'h0000 |=> !O_BUS_INTERRUPT_OUT_N)
    else $error("enabled cause did not drive bus interrupt");

  chk_enable_blocks: assert property (
    (I_CAUSE & interrupt_source_enable) == 16'h0000 && !func_drive |=> O_BUS_INTERRUPT_OUT_N)
    else $error("bus interrupt driven without enabled cause");

  chk_ack_clears_enable: assert property (
    rd_ack |=> interrupt_source_enable == 16'h0000 ##1 (O_BUS_INTERRUPT_OUT_N || $past(func_drive)))
    else $error("acknowledging read left enable set");

  chk_enable_write_bits: assert property (
    wr_enable && !rd_ack |=> interrupt_source_enable == ($past(I_REG_REQ.wdata[15:0]) & ENABLE_WRITABLE))
    else $error("enable write stored wrong bits");

  chk_modem_reserved: assert property (
    !MODEM_PRESENT |-> !interrupt_source_enable[CAUSE_MODEM_REQUEST])
    else $error("modem enable set without modem option");

  chk_func_event_sets: assert property (
    I_CARD_MODE && any_pending ##1 I_CARD_MODE |-> function_interrupt)
    else $error("function interrupt event missed pending interrupt");

  chk_wake_event_sets: assert property (
    I_CARD_MODE && I_WAKE_LIVE ##1 I_CARD_MODE |-> general_wake)
    else $error("general wake event missed live wake");

  chk_wake_power_clear: assert property (
    clr_wake && I_CARD_MODE |=> O_POWER_EVENT_CLEAR)
    else $error("wake clear did not clear power event flag");

  chk_line_flag_match: assert property (
    O_INTERRUPT_LINE_ACTIVE == !O_BUS_INTERRUPT_OUT_N)
    else $error("line active flag disagrees with bus interrupt");

  chk_irq_hold: assert property (
    next_bus_irq [*3] |=> O_BUS_INTERRUPT_OUT_N == 1'b0 && $past(O_BUS_INTERRUPT_OUT_N) == 1'b0
    && $past(O_BUS_INTERRUPT_OUT_N, 2) == 1'b0)
    else $error("bus interrupt not held while qualified");

  // Register read-back, hold and read-only behaviour
  chk_rdata_idle: assert property (
    !I_REG_REQ.rd |=> O_REG_RDATA == 32'h0000_0000)
    else $error("read data not cleared without a read");

  chk_enable_read: assert property (
    rd_enable |=> O_REG_RDATA == {16'h0000, $past(interrupt_source_enable)})
    else $error("enable read returned wrong value");

  chk_mask_read: assert property (
    rd_mask && I_CARD_MODE |=> O_REG_RDATA == ($past(status_change_mask) & 32'h0000_c010))
    else $error("mask read returned wrong value");

  chk_mask_read_off: assert property (
    rd_mask && !I_CARD_MODE |=> O_REG_RDATA == 32'h0000_0000)
    else $error("mask visible with card mode low");

  chk_mask_write_off: assert property (
    wr_mask && !I_CARD_MODE |=> $stable(status_change_mask))
    else $error("mask written with card mode low");

  chk_mask_hold: assert property (
    !wr_mask |=> $stable(status_change_mask))
    else $error("mask changed without a write");

  chk_card_latch_off: assert property (
    !I_CARD_MODE |=> !general_wake && !function_interrupt)
    else $error("event latch kept with card mode low");

  chk_present_reserved: assert property (
    rd_present |=> O_REG_RDATA[31:16] == 16'h0000 && O_REG_RDATA[14:5] == 10'h000
    && O_REG_RDATA[3:0] == 4'h0)
    else $error("present state reserved bits set");

  chk_present_read_only: assert property (
    wr_ro |=> $stable(status_change_mask) && $stable(interrupt_source_enable))
    else $error("write to read-only register changed state");

  chk_enable_hold: assert property (
    !wr_enable && !rd_ack |=> $stable(interrupt_source_enable))
    else $error("enable changed without write or acknowledge");

  chk_enable_reserved: assert property (
    interrupt_source_enable[0] == 1'b0 && interrupt_source_enable[15:12] == 4'h0)
    else $error("reserved enable bits set");

  chk_cause_read_bits: assert property (
    rd_cause |=> O_REG_RDATA == {16'h0000, $past(I_CAUSE[15:1]), $past(O_INTERRUPT_LINE_ACTIVE)})
    else $error("cause read returned wrong value");

  chk_ack_read_bits: assert property (
    rd_ack |=> O_REG_RDATA == {16'h0000, $past(I_CAUSE[15:1]), $past(O_INTERRUPT_LINE_ACTIVE)})
    else $error("acknowledging read returned wrong value");

  chk_line_follows: assert property (
    1'b1 |=> O_INTERRUPT_LINE_ACTIVE == $past(any_pending || func_drive))
    else $error("line active flag does not follow qualified sources");

  // Event gating and latch behaviour
  chk_wake_mask_gate: assert property (
    !status_change_mask[SC_GENERAL_WAKE] |=> O_STATUS_CHANGE_OUT_N)
    else $error("status change driven without general wake mask");

  chk_wake_event_gate: assert property (
    !general_wake |=> O_STATUS_CHANGE_OUT_N)
    else $error("status change driven without general wake event");

  chk_func_mask_gate: assert property (
    !status_change_mask[SC_FUNCTION_INTERRUPT] && !any_pending |=> O_BUS_INTERRUPT_OUT_N)
    else $error("bus interrupt driven by masked function event");

  chk_power_clear_cause: assert property (
    O_POWER_EVENT_CLEAR |-> $past(clr_wake && I_CARD_MODE))
    else $error("power event clear without wake clear");

  chk_force_wake_sets: assert property (
    force_wake && I_CARD_MODE |=> general_wake)
    else $error("forced general wake not latched");

  chk_force_func_sets: assert property (
    force_func && I_CARD_MODE |=> function_interrupt)
    else $error("forced function interrupt not latched");

  chk_func_clears: assert property (
    clr_func && !any_pending |=> !function_interrupt)
    else $error("function interrupt event not cleared");

  chk_wake_clears: assert property (
    clr_wake && !I_WAKE_LIVE |=> !general_wake)
    else $error("general wake event not cleared");

  cov_ack_read: cover property (interrupt_source_enable != 16'h0000 ##1 rd_ack);
  cov_card_off: cover property (I_CARD_MODE ##1 !I_CARD_MODE);
  cov_wake_sc: cover property (I_CARD_MODE && I_WAKE_LIVE ##[1:4] !O_STATUS_CHANGE_OUT_N);
  cov_func_irq: cover property (force_func ##[1:4] !O_BUS_INTERRUPT_OUT_N);
  cov_set_clear: cover property (clr_func && any_pending);

endmodule
`default_nettype wire

//--- verification/host_model.sv
// Host side model: issues one register access at a time and returns read data.
// Assumes the device answers a read on the edge after the request.
`timescale 1ns/10ps
`default_nettype none
module host_model
  import irq_sc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Register access
  output reg_req_t o_req,
  input wire logic [31:0] i_rdata
);
  initial o_req = '0;

  // Request held across the taking edge, data read back one edge later
  task automatic access(input logic wr, input reg_sel_t sel, input logic [31:0] wdata,
                        output logic [31:0] rdata);
    @(negedge i_clk);
    o_req = '{wr: wr, rd: !wr, sel: sel, wdata: wdata};
    @(negedge i_clk);
    rdata = i_rdata;
    // Stale data would hide a missed write, so the idle bus shows its inverse
    o_req = '{wr: 1'b0, rd: 1'b0, sel: SEL_NONE, wdata: ~wdata};
  endtask
endmodule
`default_nettype wire

//--- verification/irq_status_change_tb.sv
// Self-checking bench for the interrupt enable and status-change block.
// Assumes the host model drives every register access; other inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module irq_status_change_tb
  import irq_sc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic card = 1'b0;
  logic wake = 1'b0;
  logic [15:0] cause = 16'h0000;
  reg_req_t req;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic bus_n;
  logic sc_n;
  logic line;
  logic pclr;
  int err_count = 0;
  int n_tests = 0;
  int pclr_seen = 0;

  always #2 clk = ~clk;
  always @(negedge clk) if (pclr === 1'b1) pclr_seen++;

  irq_status_change #(.MODEM_PRESENT(1'b0)) dut_u (
    .I_CLK(clk), .I_SYS_RST(rst), .I_REG_REQ(req), .O_REG_RDATA(rdata), .I_CARD_MODE(card),
    .I_CAUSE(cause), .I_WAKE_LIVE(wake), .O_POWER_EVENT_CLEAR(pclr), .O_BUS_INTERRUPT_OUT_N(bus_n),
    .O_STATUS_CHANGE_OUT_N(sc_n), .O_INTERRUPT_LINE_ACTIVE(line));
  host_model host_u (.i_clk(clk), .o_req(req), .i_rdata(rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input reg_sel_t s, input logic [31:0] d);
    host_u.access(1'b1, s, d, rd);
  endtask
  task automatic rd_chk(input reg_sel_t s, input logic [31:0] e);
    host_u.access(1'b0, s, 32'h0000_0000, rd);
    check(rd, e);
  endtask
  // Latched event path needs two edges; three leaves margin
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic reset_values();
    check({bus_n, sc_n, line}, 3'b110);
    rd_chk(SEL_ENABLE, 32'h0000_0000);
  endtask

  task automatic source_gating();
    int b;
    int bits[9] = '{1, 2, 3, 4, 6, 7, 8, 9, 10};
    card = 1'b1;
    foreach (bits[i]) begin
      b = bits[i];
      wr(SEL_ENABLE, 32'h0000_0001 << b);
      cause = ~(16'h0001 << b);
      settle();
      check(bus_n, 1'b1);
      cause = 16'h0001 << b;
      settle();
      check({bus_n, line}, 2'b01);
      rd_chk(SEL_PRESENT, 32'h0000_8000);
      rd_chk(SEL_CAUSE, {16'h0000, cause[15:1], 1'b1});
      cause = 16'h0000;
    end
  endtask

  task automatic reserved_bits();
    wr(SEL_ENABLE, 32'hffff_ffff);
    rd_chk(SEL_ENABLE, {16'h0000, ENABLE_WRITABLE_BASE});
    wr(SEL_CAUSE, 32'h0000_0000);
    rd_chk(SEL_ENABLE, {16'h0000, ENABLE_WRITABLE_BASE});
    rd_chk(SEL_FORCE, 32'h0000_0000);
    cause = 16'h0821;
    settle();
    check(bus_n, 1'b1);
    cause = 16'h0000;
  endtask

  task automatic ack_clears();
    wr(SEL_ENABLE, 32'h0000_0004);
    cause = 16'h0004;
    settle();
    rd_chk(SEL_CAUSE_ACK, 32'h0000_0005);
    settle();
    check(bus_n, 1'b1);
    rd_chk(SEL_ENABLE, 32'h0000_0000);
    cause = 16'h0000;
  endtask

  task automatic wake_path();
    wr(SEL_LATCH, 32'h0000_8010);
    wr(SEL_MASK, 32'h0000_0010);
    wake = 1'b1;
    settle();
    check(sc_n, 1'b1);
    rd_chk(SEL_PRESENT, 32'h0000_0010);
    wr(SEL_MASK, 32'h0000_4010);
    settle();
    check(sc_n, 1'b0);
    wr(SEL_LATCH, 32'h0000_0010);
    settle();
    check(sc_n, 1'b0);
    wake = 1'b0;
    pclr_seen = 0;
    wr(SEL_LATCH, 32'h0000_0010);
    settle();
    check(sc_n, 1'b1);
    check(pclr_seen, 32'h0000_0001);
    rd_chk(SEL_LATCH, 32'h0000_0000);
  endtask

  task automatic function_function_interrupt();
    wr(SEL_MASK, 32'h0000_8000);
    wr(SEL_FORCE, 32'h0000_8000);
    settle();
    check(bus_n, 1'b0);
    rd_chk(SEL_LATCH, 32'h0000_8000);
    wr(SEL_LATCH, 32'h0000_8000);
    settle();
    check(bus_n, 1'b1);
    wr(SEL_MASK, 32'h0000_0000);
    wr(SEL_ENABLE, 32'h0000_0040);
    cause = 16'h0040;
    settle();
    rd_chk(SEL_LATCH, 32'h0000_8000);
    cause = 16'h0000;
  endtask

  task automatic card_off();
    wr(SEL_MASK, 32'h0000_c010);
    wake = 1'b1;
    settle();
    check(sc_n, 1'b0);
    card = 1'b0;
    settle();
    check(sc_n, 1'b1);
    rd_chk(SEL_MASK, 32'h0000_0000);
    rd_chk(SEL_PRESENT, 32'h0000_0000);
    wake = 1'b0;
    wr(SEL_MASK, 32'h0000_0000);
    card = 1'b1;
    rd_chk(SEL_MASK, 32'h0000_c010);
  endtask

  task automatic close_out();
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    reset_values();
    source_gating();
    reserved_bits();
    ack_clears();
    wake_path();
    function_function_interrupt();
    card_off();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (5000) @(negedge clk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
